/* smpg_consts.svh */
// Constants for the sleep and power-gating controller
`ifndef SMPG_CONSTS_SVH
`define SMPG_CONSTS_SVH
`define SMPG_MODE_IDLE 2'h0
`define SMPG_MODE_ADCNR 2'h1
`define SMPG_MODE_PDOWN 2'h2
`define SMPG_MODE_STBY 2'h3
`define SMPG_HALT_CYCLES 4
`define SMPG_STBY_WAKE_CYCLES 6
`define SMPG_OSC_START_DEFAULT 16
`define SMPG_GATE_RESET 8'h00
`define SMPG_GATE_MASK 8'h7f
`define SMPG_GATE_ADC 0
`define SMPG_GATE_UART0 1
`define SMPG_GATE_UART1 2
`define SMPG_GATE_USP 3
`define SMPG_GATE_TIM0 4
`define SMPG_GATE_TIM1 5
`define SMPG_GATE_TWS 6
`endif

/* smpg_pkg.sv */
// Types for the sleep and power-gating controller
package smpg_pkg;
    typedef enum logic [2:0] {ST_ACTIVE, ST_SLEEP, ST_START, ST_HALT} smpg_state_t;
    typedef struct packed {
        logic ext0_level;
        logic ext0_edge;
        logic pin_change;
        logic watchdog;
        logic timer_ovf;
        logic comparator;
        logic adc_done;
        logic store_ready;
        logic usp_start;
        logic usp_other;
        logic uart_frame;
        logic uart_other;
        logic tws_addr;
        logic tws_other;
        logic other_io;
    } smpg_wake_t;
    typedef struct packed {
        logic cpu;
        logic flash;
        logic io;
        logic adc;
        logic osc;
    } smpg_clk_t;
endpackage : smpg_pkg

/* smpg_ctrl.sv */
// Sleep mode sequencer and peripheral clock gating
// Function
// - Sleep only if arm bit set at instruction
// - Mode field selects Idle, ADCNR, Powerdown, Standby
// - Halt four cycles after startup on wake
// - Register file and SRAM kept through sleep
// - Reset during sleep wakes to reset vector
// - Idle stops only CPU and flash clocks
// - Idle wakes on any enabled interrupt
// - Comparator off in Idle when disabled
// - Idle or ADCNR entry starts ADC conversion
// - ADCNR stops IO, CPU and flash clocks
// - ADCNR wake sources as listed
// - Powerdown stops all clocks, asynchronous wakes remain
// - Powerdown stops oscillator, limited wake sources
// - Deeper modes narrow some wake sources
// - Standby like Powerdown, wake in six cycles
// - Gated peripheral frozen, registers inaccessible
// - Ungating resumes peripheral exactly as before
// - Gate bits matter in Active and Idle
// - Gate register layout, reset zero, bit7 zero
`timescale 1ns/1ps
`include "smpg_consts.svh"
module smpg_ctrl #(
    parameter int OSC_START_CYCLES = `SMPG_OSC_START_DEFAULT
) (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic SLEEP_EXEC,
    input wire logic SLEEP_ARM_BIT,
    input wire logic [1:0] SLEEP_MODE_SELECT,
    input wire logic COMPARATOR_DISABLE_BIT,
    input wire logic ADC_ENABLED,
    input wire logic [7:0] GATE_WR_DATA,
    input wire logic GATE_WR,
    input wire smpg_pkg::smpg_wake_t WAKE_REQ,
    output logic CPU_HALT,
    output logic WAKE_IRQ_PULSE,
    output logic SLEEPING,
    output logic ADC_START,
    output smpg_pkg::smpg_clk_t CLK_EN,
    output logic [7:0] PERIPH_CLK_EN,
    output logic [7:0] PERIPHERAL_CLOCK_GATE_REG,
    output logic COMPARATOR_POWER
);
    localparam int HALT_CYCLES = `SMPG_HALT_CYCLES;
    localparam int STBY_CYCLES = `SMPG_STBY_WAKE_CYCLES;
    localparam int START_CYCLES = OSC_START_CYCLES < 1 ? 1 : OSC_START_CYCLES;

    smpg_pkg::smpg_state_t state_r, state_nxt;
    logic [1:0] mode_r, mode_nxt;
    logic [15:0] cnt_r, cnt_nxt;
    logic [7:0] gate_r;
    smpg_pkg::smpg_wake_t wake_s1_r, wake_s2_r;
    logic halt_r, pulse_r, sleeping_r, adc_start_r, comp_pwr_r;
    smpg_pkg::smpg_clk_t clk_en_r, clk_en_nxt;
    logic [7:0] pclk_r;

    // Mode dependent wake qualification
    function automatic logic wake_ok(input logic [1:0] m, input smpg_pkg::smpg_wake_t w,
                                     input logic comp_off);
        logic deep;
        deep = (m != `SMPG_MODE_IDLE);
        if (!deep) begin
            wake_ok = w.ext0_level | w.ext0_edge | w.pin_change | w.watchdog | w.timer_ovf
                | (w.comparator & ~comp_off) | w.adc_done | w.store_ready | w.usp_start
                | w.usp_other | w.uart_frame | w.uart_other | w.tws_addr | w.tws_other
                | w.other_io;
        end else begin
            wake_ok = w.ext0_level | w.pin_change | w.watchdog | w.usp_start | w.uart_frame
                | w.tws_addr;
            if (m == `SMPG_MODE_ADCNR) begin
                wake_ok = wake_ok | w.adc_done | w.store_ready;
            end
        end
    endfunction : wake_ok

    // Clock enables per state and mode
    function automatic smpg_pkg::smpg_clk_t clocks_for(input logic asleep, input logic [1:0] m);
        smpg_pkg::smpg_clk_t c;
        c = '{cpu: 1'b1, flash: 1'b1, io: 1'b1, adc: 1'b1, osc: 1'b1};
        if (asleep) begin
            c.cpu = 1'b0;
            c.flash = 1'b0;
            c.io = (m == `SMPG_MODE_IDLE);
            c.adc = (m == `SMPG_MODE_IDLE) || (m == `SMPG_MODE_ADCNR);
            c.osc = (m != `SMPG_MODE_PDOWN);
        end
        clocks_for = c;
    endfunction : clocks_for

    wire logic enter = SLEEP_EXEC && SLEEP_ARM_BIT;
    wire logic wake_hit = wake_ok(mode_r, wake_s2_r, COMPARATOR_DISABLE_BIT);
    wire logic [15:0] start_len = (mode_r == `SMPG_MODE_STBY) ?
        16'(STBY_CYCLES - HALT_CYCLES - 1) : 16'(START_CYCLES);
    wire logic asleep_nxt = (state_nxt == smpg_pkg::ST_SLEEP) || (state_nxt == smpg_pkg::ST_START);
    // Gates apply in Active and Idle; deeper modes already stop these clocks
    wire logic periph_run = !asleep_nxt || (mode_nxt == `SMPG_MODE_IDLE);

    always_comb begin
        state_nxt = state_r;
        mode_nxt = mode_r;
        cnt_nxt = cnt_r;
        case (state_r)
            smpg_pkg::ST_ACTIVE: begin
                if (enter) begin
                    state_nxt = smpg_pkg::ST_SLEEP;
                    mode_nxt = SLEEP_MODE_SELECT;
                end
            end
            smpg_pkg::ST_SLEEP: begin
                if (wake_hit) begin
                    state_nxt = smpg_pkg::ST_START;
                    cnt_nxt = start_len;
                end
            end
            smpg_pkg::ST_START: begin
                if (cnt_r <= 16'h0001) begin
                    state_nxt = smpg_pkg::ST_HALT;
                    cnt_nxt = 16'(HALT_CYCLES);
                end else begin
                    cnt_nxt = cnt_r - 16'h0001;
                end
            end
            smpg_pkg::ST_HALT: begin
                if (cnt_r <= 16'h0001) begin
                    state_nxt = smpg_pkg::ST_ACTIVE;
                end else begin
                    cnt_nxt = cnt_r - 16'h0001;
                end
            end
            default: state_nxt = smpg_pkg::ST_ACTIVE;
        endcase
        clk_en_nxt = clocks_for(asleep_nxt, mode_nxt);
    end

    // Async reset wakes straight to reset vector; no state restored
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state_r <= smpg_pkg::ST_ACTIVE;
            mode_r <= `SMPG_MODE_IDLE;
            cnt_r <= 16'h0000;
            wake_s1_r <= '0;
            wake_s2_r <= '0;
        end else begin
            state_r <= state_nxt;
            mode_r <= mode_nxt;
            cnt_r <= cnt_nxt;
            wake_s1_r <= WAKE_REQ;
            wake_s2_r <= wake_s1_r;
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            gate_r <= `SMPG_GATE_RESET;
        end else if (GATE_WR) begin
            gate_r <= GATE_WR_DATA & `SMPG_GATE_MASK;
        end
    end

    // Only clocks and comparator power are withheld; peripheral and memory state never reset here
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            halt_r <= 1'b0;
            pulse_r <= 1'b0;
            sleeping_r <= 1'b0;
            adc_start_r <= 1'b0;
            comp_pwr_r <= 1'b1;
            clk_en_r <= '{cpu: 1'b1, flash: 1'b1, io: 1'b1, adc: 1'b1, osc: 1'b1};
            pclk_r <= `SMPG_GATE_MASK;
        end else begin
            halt_r <= (state_nxt != smpg_pkg::ST_ACTIVE);
            pulse_r <= (state_r == smpg_pkg::ST_HALT) && (state_nxt == smpg_pkg::ST_ACTIVE);
            sleeping_r <= asleep_nxt;
            adc_start_r <= enter && ADC_ENABLED && (state_r == smpg_pkg::ST_ACTIVE)
                && (SLEEP_MODE_SELECT == `SMPG_MODE_IDLE
                    || SLEEP_MODE_SELECT == `SMPG_MODE_ADCNR);
            comp_pwr_r <= !(asleep_nxt && COMPARATOR_DISABLE_BIT);
            clk_en_r <= clk_en_nxt;
            pclk_r <= periph_run ? (~gate_r & `SMPG_GATE_MASK) : 8'h00;
        end
    end

    assign CPU_HALT = halt_r;
    assign WAKE_IRQ_PULSE = pulse_r;
    assign SLEEPING = sleeping_r;
    assign ADC_START = adc_start_r;
    assign CLK_EN = clk_en_r;
    assign PERIPH_CLK_EN = pclk_r;
    assign PERIPHERAL_CLOCK_GATE_REG = gate_r;
    assign COMPARATOR_POWER = comp_pwr_r;

    a_halt_after_start: assert property (@(posedge CLK) disable iff (SYS_RST)
        (state_r == smpg_pkg::ST_START && state_nxt == smpg_pkg::ST_HALT)
        |=> (state_r == smpg_pkg::ST_HALT) [*4] ##1 state_r == smpg_pkg::ST_ACTIVE)
        else $error("halt not four cycles");
    a_no_arm_sleep: assert property (@(posedge CLK) disable iff (SYS_RST)
        (state_r == smpg_pkg::ST_ACTIVE && !SLEEP_ARM_BIT) |=> state_r != smpg_pkg::ST_SLEEP)
        else $error("sleep without arm");
    a_pdown_osc_off: assert property (@(posedge CLK) disable iff (SYS_RST)
        (SLEEPING && mode_r == `SMPG_MODE_PDOWN) |-> !CLK_EN.osc && !CLK_EN.adc)
        else $error("oscillator on in powerdown");
    a_idle_clocks: assert property (@(posedge CLK) disable iff (SYS_RST)
        (SLEEPING && mode_r == `SMPG_MODE_IDLE) |-> CLK_EN.io && CLK_EN.osc && !CLK_EN.cpu)
        else $error("idle clocks wrong");
    a_stby_wake_six: assert property (@(posedge CLK) disable iff (SYS_RST)
        (state_r == smpg_pkg::ST_SLEEP && wake_hit && mode_r == `SMPG_MODE_STBY)
        |-> ##6 state_r == smpg_pkg::ST_ACTIVE)
        else $error("standby wake not six cycles");
    a_gate_bit7: assert property (@(posedge CLK) disable iff (SYS_RST)
        !PERIPHERAL_CLOCK_GATE_REG[7])
        else $error("gate bit7 set");
    a_gate_freezes: assert property (@(posedge CLK) disable iff (SYS_RST)
        $rose(gate_r[`SMPG_GATE_TIM0]) |=> !PERIPH_CLK_EN[`SMPG_GATE_TIM0])
        else $error("gated clock still on");
    a_deep_no_timer: assert property (@(posedge CLK) disable iff (SYS_RST)
        (state_r == smpg_pkg::ST_SLEEP && mode_r != `SMPG_MODE_IDLE
         && wake_s2_r == smpg_pkg::smpg_wake_t'(15'h0400)) |=> state_r == smpg_pkg::ST_SLEEP)
        else $error("timer woke deep mode");

    // Steps of a sleep entry and of the deep sleep states
    sequence s_enter;
        state_r == smpg_pkg::ST_ACTIVE && enter;
    endsequence
    sequence s_asleep;
        state_r == smpg_pkg::ST_SLEEP && SLEEPING && CPU_HALT;
    endsequence
    sequence s_deep_asleep;
        SLEEPING && mode_r != `SMPG_MODE_IDLE;
    endsequence

    a_enter_sleeps: assert property (@(posedge CLK) disable iff (SYS_RST)
        s_enter |=> s_asleep)
        else $error("armed sleep not entered");

    a_mode_latched: assert property (@(posedge CLK) disable iff (SYS_RST)
        s_enter |=> mode_r == $past(SLEEP_MODE_SELECT))
        else $error("sleep mode not latched");

    a_adcnr_clocks: assert property (@(posedge CLK) disable iff (SYS_RST)
        (SLEEPING && mode_r == `SMPG_MODE_ADCNR)
        |-> !CLK_EN.io && CLK_EN.adc && CLK_EN.osc && !CLK_EN.cpu && !CLK_EN.flash)
        else $error("noise reduction clocks wrong");

    a_stby_osc_on: assert property (@(posedge CLK) disable iff (SYS_RST)
        (SLEEPING && mode_r == `SMPG_MODE_STBY) |-> CLK_EN.osc && !CLK_EN.io && !CLK_EN.adc)
        else $error("standby clocks wrong");

    a_pdown_all_off: assert property (@(posedge CLK) disable iff (SYS_RST)
        (SLEEPING && mode_r == `SMPG_MODE_PDOWN) |-> CLK_EN == '0)
        else $error("powerdown clock still running");

    a_adc_start_pulse: assert property (@(posedge CLK) disable iff (SYS_RST)
        ADC_START |=> !ADC_START)
        else $error("conversion start not a pulse");

    a_cmp_power_off: assert property (@(posedge CLK) disable iff (SYS_RST)
        (asleep_nxt && COMPARATOR_DISABLE_BIT) |=> !COMPARATOR_POWER)
        else $error("comparator powered while disabled");

    a_deep_periph_off: assert property (@(posedge CLK) disable iff (SYS_RST)
        s_deep_asleep |-> PERIPH_CLK_EN == 8'h00)
        else $error("peripheral clock on in deep sleep");

    a_periph_bit7: assert property (@(posedge CLK) disable iff (SYS_RST)
        !PERIPH_CLK_EN[7])
        else $error("unused peripheral clock on");

    a_wake_releases: assert property (@(posedge CLK) disable iff (SYS_RST)
        WAKE_IRQ_PULSE |-> !CPU_HALT && !SLEEPING)
        else $error("wake pulse while halted");

    a_gate_write: assert property (@(posedge CLK) disable iff (SYS_RST)
        GATE_WR |=> PERIPHERAL_CLOCK_GATE_REG == ($past(GATE_WR_DATA) & `SMPG_GATE_MASK))
        else $error("gate write lost");

    a_ungate_restart: assert property (@(posedge CLK) disable iff (SYS_RST)
        (!gate_r[`SMPG_GATE_TIM0] && periph_run) |=> PERIPH_CLK_EN[`SMPG_GATE_TIM0])
        else $error("ungated clock not restarted");

    a_sleep_keeps_gate: assert property (@(posedge CLK) disable iff (SYS_RST)
        (SLEEPING && !GATE_WR) |=> $stable(PERIPHERAL_CLOCK_GATE_REG))
        else $error("gate register changed in sleep");

    a_start_cpu_off: assert property (@(posedge CLK) disable iff (SYS_RST)
        state_r == smpg_pkg::ST_START |-> CPU_HALT && !CLK_EN.cpu)
        else $error("cpu clock on during start-up");

    a_halt_cpu_clock: assert property (@(posedge CLK) disable iff (SYS_RST)
        state_r == smpg_pkg::ST_HALT |-> CPU_HALT && CLK_EN.cpu)
        else $error("halt state clocks wrong");
endmodule : smpg_ctrl

/* smpg_wake_model.sv */
// Peripheral wake sources that hold their request until the core takes it
`timescale 1ns/1ps
module smpg_wake_model (
    input wire logic clk,
    input wire logic sys_rst,
    input wire smpg_pkg::smpg_wake_t set_req,
    input wire logic set_stb,
    input wire logic clr_stb,
    input wire logic irq_taken,
    output smpg_pkg::smpg_wake_t wake_req
);
    // Level held until serviced or withdrawn
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            wake_req <= '0;
        end else if (set_stb) begin
            wake_req <= set_req;
        end else if (irq_taken || clr_stb) begin
            wake_req <= '0;
        end
    end
endmodule : smpg_wake_model

/* smpg_ctrl_test.sv */
// Self-checking bench for the sleep and power-gating controller
`timescale 1ns/1ps
`include "smpg_consts.svh"
module smpg_ctrl_test;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic sleep_exec = 1'b0;
    logic arm = 1'b0;
    logic cmp_dis = 1'b0;
    logic adc_en = 1'b0;
    logic gate_wr = 1'b0;
    logic set_stb = 1'b0;
    logic clr_stb = 1'b0;
    logic [1:0] mode = 2'h0;
    logic [7:0] gate_data = 8'h00;
    smpg_pkg::smpg_wake_t set_req = '0;
    smpg_pkg::smpg_wake_t wake_req;
    smpg_pkg::smpg_clk_t clk_en;
    logic cpu_halt, irq, sleeping, adc_start, comp_pwr;
    logic [7:0] periph_en, gate_reg;
    int n_mismatch = 0;
    int n_checks = 0;
    int cyc = 0;
    // Enabled domains {cpu,flash,io,adc,osc} per mode
    logic [4:0] exp_clk [4] = '{5'h07, 5'h03, 5'h00, 5'h01};
    // Mode, refused source, accepted source
    logic [1:0] t_mode [6] = '{2'h1, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
    logic [14:0] t_bad [6] = '{15'h0400, 15'h2000, 15'h0100, 15'h0080, 15'h0008, 15'h0001};
    logic [14:0] t_good [6] = '{15'h1000, 15'h0100, 15'h0010, 15'h0040, 15'h0004, 15'h0800};

    initial begin
        forever #5 clk = ~clk;
    end

    smpg_ctrl #(.OSC_START_CYCLES(8)) i_smpg_ctrl (.CLK(clk), .SYS_RST(sys_rst),
        .SLEEP_EXEC(sleep_exec), .SLEEP_ARM_BIT(arm), .SLEEP_MODE_SELECT(mode),
        .COMPARATOR_DISABLE_BIT(cmp_dis), .ADC_ENABLED(adc_en), .GATE_WR_DATA(gate_data),
        .GATE_WR(gate_wr), .WAKE_REQ(wake_req), .CPU_HALT(cpu_halt), .WAKE_IRQ_PULSE(irq),
        .SLEEPING(sleeping), .ADC_START(adc_start), .CLK_EN(clk_en), .PERIPH_CLK_EN(periph_en),
        .PERIPHERAL_CLOCK_GATE_REG(gate_reg), .COMPARATOR_POWER(comp_pwr));

    smpg_wake_model i_smpg_wake_model (.clk(clk), .sys_rst(sys_rst), .set_req(set_req),
        .set_stb(set_stb), .clr_stb(clr_stb), .irq_taken(irq), .wake_req(wake_req));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check

    task automatic go_sleep(input logic [1:0] m, input logic a);
        @(posedge clk);
        arm <= a;
        mode <= m;
        sleep_exec <= 1'b1;
        @(posedge clk);
        sleep_exec <= 1'b0;
        #1;
    endtask : go_sleep

    // Raise a source; lo = hi = 40 means it must be refused
    task automatic wake(input logic [14:0] src, input int lo, input int hi);
        int n;
        n = 0;
        @(posedge clk);
        set_req <= smpg_pkg::smpg_wake_t'(src);
        set_stb <= 1'b1;
        @(posedge clk);
        set_stb <= 1'b0;
        #1;
        while (irq !== 1'b1 && n < 40) begin
            @(posedge clk);
            #1;
            n++;
        end
        check(16'(n >= lo && n <= hi), 16'h1);
        if (n >= 40) begin
            @(posedge clk);
            clr_stb <= 1'b1;
            @(posedge clk);
            clr_stb <= 1'b0;
        end else begin
            @(posedge clk);
            #1;
            check({irq, cpu_halt, sleeping}, 16'h0);
        end
    endtask : wake

    task automatic gate_write(input logic [7:0] d);
        @(posedge clk);
        gate_data <= d;
        gate_wr <= 1'b1;
        @(posedge clk);
        gate_wr <= 1'b0;
        @(posedge clk);
        #1;
    endtask : gate_write

    task automatic test_done;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : test_done

    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            test_done();
        end
    end

    initial begin
        repeat (10) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        check({clk_en, periph_en, gate_reg}, {5'h1f, 8'h7f, `SMPG_GATE_RESET});
        go_sleep(`SMPG_MODE_IDLE, 1'b0);
        check(sleeping, 1'b0);
        adc_en <= 1'b1;
        for (int m = 0; m < 4; m++) begin
            go_sleep(2'(m), 1'b1);
            check(clk_en, exp_clk[m]);
            check(adc_start, 16'(m < 2));
            if (m != 1) check(periph_en, m == 0 ? 8'h7f : 8'h00);
            wake(15'h4000, m == 3 ? 5 : 11, m == 3 ? 10 : 18);
        end
        for (int k = 0; k < 6; k++) begin
            go_sleep(t_mode[k], 1'b1);
            wake(t_bad[k], 40, 40);
            check(sleeping, 1'b1);
            wake(t_good[k], t_mode[k] == 3 ? 5 : 11, t_mode[k] == 3 ? 10 : 18);
        end
        cmp_dis <= 1'b1;
        go_sleep(`SMPG_MODE_IDLE, 1'b1);
        check(comp_pwr, 1'b0);
        wake(15'h0200, 40, 40);
        wake(15'h0001, 11, 18);
        cmp_dis <= 1'b0;
        adc_en <= 1'b0;
        go_sleep(`SMPG_MODE_ADCNR, 1'b1);
        check(adc_start, 1'b0);
        wake(15'h0400 | 15'h1000, 11, 18);
        gate_write(8'hff);
        check({gate_reg, periph_en}, 16'h7f00);
        gate_write(8'h05);
        check({gate_reg, periph_en}, 16'h057a);
        go_sleep(`SMPG_MODE_IDLE, 1'b1);
        check(periph_en, 8'h7a);
        wake(15'h0400, 11, 18);
        go_sleep(`SMPG_MODE_PDOWN, 1'b1);
        check(sleeping, 1'b1);
        @(posedge clk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge clk);
        sys_rst <= 1'b0;
        #1;
        check({sleeping, cpu_halt, clk_en, gate_reg}, {2'h0, 5'h1f, 8'h00});
        test_done();
    end
endmodule : smpg_ctrl_test
